/* hw/cbt_consts.svh */
// Constants for the CAN bit timing and interrupt configuration block
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH
`define CBT_OFS_CON 4'h0
`define CBT_OFS_CFG 4'h4
`define CBT_OFS_INT 4'h8
`define CBT_CON_EN 15
`define CBT_CON_ACT 11
`define CBT_CON_REQ 26:24
`define CBT_CON_STAT 23:21
`define CBT_CON_CNT 4:0
`define CBT_CON_WMASK 32'h0700_801f
`define CBT_CON_RST 32'h0480_0000
`define CBT_MODE_CFG 3'h4
`define CBT_CFG_WMASK 32'h0047_ffff
`define CBT_CFG_WAKF 22
`define CBT_CFG_SEG2 18:16
`define CBT_CFG_FREE 15
`define CBT_CFG_SAM 14
`define CBT_CFG_SEG1 13:11
`define CBT_CFG_PROP 10:8
`define CBT_CFG_SJW 7:6
`define CBT_CFG_BRP 5:0
`define CBT_INT_ENMASK 32'hf80f_0000
`define CBT_INT_FLMASK 32'h0000_f80f
`define CBT_INT_SERR 12
`define CBT_INT_MODF 3
`define CBT_IPT_TQ 4'h2
`endif

/* hw/cbt_pkg.sv */
// Types for the CAN bit timing and interrupt configuration block
package cbt_pkg;
  typedef enum logic [1:0] {SEG_SYNC = 2'b00, SEG_PROP = 2'b01, SEG_PH1 = 2'b10, SEG_PH2 = 2'b11} cbt_seg_t;
  typedef enum logic [1:0] {MOD_OFF = 2'b00, MOD_RUN = 2'b01, MOD_DRAIN = 2'b10} cbt_mod_t;
endpackage : cbt_pkg

/* hw/cbt_top.sv */
// CAN bit timing generator with control, timing and interrupt registers
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cbt_consts.svh"
module cbt_top #(
  parameter int WAKE_FILT_CYC = 8
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Bus and protocol side
  input wire logic rx_in,
  input wire logic frame_busy_in,
  input wire logic [7:0] hw_evt_in,
  // Results
  output logic irq_out,
  output logic active_out,
  output logic [2:0] op_mode_out,
  output logic [4:0] data_cmp_count_out,
  output logic wake_rx_out,
  output logic bit_start_out,
  output logic sample_strobe_out,
  output logic sample_out
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic [31:0] con_reg, cfg_reg, int_reg, bemask, rd_next;
  logic wr_go, req;
  cbt_pkg::cbt_mod_t mod_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_be
      assign bemask[gi*8 +: 8] = {8{byteenable_in[gi]}};
    end
  endgenerate
  assign req = read_in | write_in;
  assign wr_go = ce_in & write_in & ~waitrequest_out;
  always_comb
  begin
    case (address_in)
      `CBT_OFS_CON: rd_next = con_reg;
      `CBT_OFS_CFG: rd_next = cfg_reg;
      `CBT_OFS_INT: rd_next = int_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end
  // One wait state, then the answer
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      if (req && waitrequest_out)
      begin
        waitrequest_out <= 1'b0;
        readdata_out <= rd_next;
      end
      else
        waitrequest_out <= 1'b1;
    end
  end
  // ****************************************
  // Control and mode
  // ****************************************
  logic en_wr, en_prev_reg, mode_evt;
  logic [31:0] con_w;
  assign con_w = (con_reg & ~bemask) | (writedata_in & bemask);
  assign en_wr = wr_go && address_in == `CBT_OFS_CON;
  assign mode_evt = ce_in && mod_reg != cbt_pkg::MOD_OFF && !frame_busy_in
    && con_reg[`CBT_CON_STAT] != con_reg[`CBT_CON_REQ];
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      con_reg <= `CBT_CON_RST;
    else if (ce_in)
    begin
      if (en_wr)
        con_reg <= (con_reg & ~`CBT_CON_WMASK) | (con_w & `CBT_CON_WMASK);
      if (mode_evt)
        con_reg[`CBT_CON_STAT] <= con_reg[`CBT_CON_REQ];
      con_reg[`CBT_CON_ACT] <= mod_reg != cbt_pkg::MOD_OFF;
    end
  end
  // Disable waits for the frame in flight to finish
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      mod_reg <= cbt_pkg::MOD_OFF;
    else if (ce_in)
    begin
      case (mod_reg)
        cbt_pkg::MOD_OFF: if (con_reg[`CBT_CON_EN]) mod_reg <= cbt_pkg::MOD_RUN;
        cbt_pkg::MOD_RUN: if (!con_reg[`CBT_CON_EN]) mod_reg <= cbt_pkg::MOD_DRAIN;
        cbt_pkg::MOD_DRAIN: if (!frame_busy_in) mod_reg <= cbt_pkg::MOD_OFF;
        default: mod_reg <= cbt_pkg::MOD_OFF;
      endcase
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      active_out <= 1'b0;
      op_mode_out <= `CBT_MODE_CFG;
      data_cmp_count_out <= 5'h00;
      en_prev_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      active_out <= mod_reg != cbt_pkg::MOD_OFF;
      op_mode_out <= con_reg[`CBT_CON_STAT];
      data_cmp_count_out <= con_reg[`CBT_CON_CNT];
      en_prev_reg <= con_reg[`CBT_CON_EN];
    end
  end
  // ****************************************
  // Bit timing register
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      cfg_reg <= 32'h0000_0000;
    else if (wr_go && address_in == `CBT_OFS_CFG && con_reg[`CBT_CON_STAT] == `CBT_MODE_CFG)
      cfg_reg <= (cfg_reg & ~bemask) | (writedata_in & bemask & `CBT_CFG_WMASK);
  end
  // ****************************************
  // Interrupt register
  // ****************************************
  logic [31:0] evt_vec, clr_vec;
  logic en_rise;
  assign en_rise = con_reg[`CBT_CON_EN] & ~en_prev_reg;
  assign evt_vec = {16'h0000, hw_evt_in[7:3], 7'h00, mode_evt, hw_evt_in[2:0]};
  always_comb
  begin
    clr_vec = 32'h0000_0000;
    if (wr_go && address_in == `CBT_OFS_INT)
      clr_vec = ~writedata_in & bemask & `CBT_INT_FLMASK;
    clr_vec[`CBT_INT_SERR] = en_rise;
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      int_reg <= 32'h0000_0000;
      irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_go && address_in == `CBT_OFS_INT)
        int_reg <= ((int_reg & ~`CBT_INT_ENMASK) | (writedata_in & bemask & `CBT_INT_ENMASK)
          | (int_reg & `CBT_INT_ENMASK & ~bemask)) & ~clr_vec | (int_reg & `CBT_INT_FLMASK & ~clr_vec)
          | evt_vec;
      else
        int_reg <= (int_reg & ~clr_vec) | evt_vec;
      irq_out <= |(int_reg[31:16] & int_reg[15:0]);
    end
  end
  // ****************************************
  // Wake-up line filter
  // ****************************************
  logic [7:0] wf_cnt_reg;
  logic wf_reg;
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      wf_cnt_reg <= 8'h00;
      wf_reg <= 1'b1;
      wake_rx_out <= 1'b1;
    end
    else if (ce_in)
    begin
      if (rx_in == wf_reg)
        wf_cnt_reg <= 8'h00;
      else if (wf_cnt_reg == 8'(WAKE_FILT_CYC - 1))
      begin
        wf_reg <= rx_in;
        wf_cnt_reg <= 8'h00;
      end
      else
        wf_cnt_reg <= wf_cnt_reg + 8'h01;
      wake_rx_out <= cfg_reg[`CBT_CFG_WAKF] ? wf_reg : rx_in;
    end
  end
  // ****************************************
  // Bit timing engine
  // ****************************************
  cbt_pkg::cbt_seg_t seg_reg;
  logic [6:0] presc_reg, tq_reload;
  logic [3:0] qcnt_reg, ext_reg, ph1_len, ph2_len, jump, ph1_n;
  logic [2:0] hist_reg;
  logic run, tick, half, rx_prev_reg, resync_done_reg, fall, maj, sp;
  assign run = mod_reg == cbt_pkg::MOD_RUN && con_reg[`CBT_CON_STAT] != `CBT_MODE_CFG;
  assign tq_reload = {cfg_reg[`CBT_CFG_BRP], 1'b1};
  assign tick = presc_reg == 7'h00;
  assign half = presc_reg == {1'b0, cfg_reg[`CBT_CFG_BRP]};
  assign jump = {2'b00, cfg_reg[`CBT_CFG_SJW]} + 4'h1;
  assign ph1_n = {1'b0, cfg_reg[`CBT_CFG_SEG1]} + 4'h1;
  assign ph1_len = ph1_n + ext_reg;
  assign ph2_len = cfg_reg[`CBT_CFG_FREE] ? {1'b0, cfg_reg[`CBT_CFG_SEG2]} + 4'h1
    : (ph1_n > `CBT_IPT_TQ ? ph1_n : `CBT_IPT_TQ);
  assign fall = rx_prev_reg & ~rx_in;
  assign maj = (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & rx_in) | (hist_reg[0] & rx_in);
  assign sp = run && tick && seg_reg == cbt_pkg::SEG_PH1 && qcnt_reg >= ph1_len - 4'h1;
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || (ce_in && !run))
      presc_reg <= 7'h00;
    else if (ce_in)
      presc_reg <= tick ? tq_reload : presc_reg - 7'h01;
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || (ce_in && !run))
    begin
      seg_reg <= cbt_pkg::SEG_SYNC;
      qcnt_reg <= 4'h0;
      ext_reg <= 4'h0;
      resync_done_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (fall && !resync_done_reg && seg_reg != cbt_pkg::SEG_SYNC)
      begin
        resync_done_reg <= 1'b1;
        if (seg_reg == cbt_pkg::SEG_PH2)
          qcnt_reg <= qcnt_reg + jump;
        else
          ext_reg <= jump;
      end
      else if (tick)
      begin
        qcnt_reg <= qcnt_reg + 4'h1;
        case (seg_reg)
          cbt_pkg::SEG_SYNC:
          begin
            seg_reg <= cbt_pkg::SEG_PROP;
            qcnt_reg <= 4'h0;
          end
          cbt_pkg::SEG_PROP:
            if (qcnt_reg >= {1'b0, cfg_reg[`CBT_CFG_PROP]})
            begin
              seg_reg <= cbt_pkg::SEG_PH1;
              qcnt_reg <= 4'h0;
            end
          cbt_pkg::SEG_PH1:
            if (qcnt_reg >= ph1_len - 4'h1)
            begin
              seg_reg <= cbt_pkg::SEG_PH2;
              qcnt_reg <= 4'h0;
            end
          cbt_pkg::SEG_PH2:
            if (qcnt_reg >= ph2_len - 4'h1)
            begin
              seg_reg <= cbt_pkg::SEG_SYNC;
              qcnt_reg <= 4'h0;
              ext_reg <= 4'h0;
              resync_done_reg <= 1'b0;
            end
          default: seg_reg <= cbt_pkg::SEG_SYNC;
        endcase
      end
    end
  end
  // Half-quantum history feeds the three-sample vote
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      hist_reg <= 3'h7;
      rx_prev_reg <= 1'b1;
      sample_out <= 1'b1;
      sample_strobe_out <= 1'b0;
      bit_start_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rx_prev_reg <= rx_in;
      if (half)
        hist_reg <= {hist_reg[1:0], rx_in};
      if (sp)
        sample_out <= cfg_reg[`CBT_CFG_SAM] ? maj : rx_in;
      sample_strobe_out <= sp;
      bit_start_out <= run && tick && seg_reg == cbt_pkg::SEG_SYNC;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in || !ce_in);
  property p_cfg_lock;
    wr_go && address_in == `CBT_OFS_CFG && con_reg[`CBT_CON_STAT] != `CBT_MODE_CFG |=> $stable(cfg_reg);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("timing register changed outside config mode");
  property p_mode_flag;
    $changed(con_reg[`CBT_CON_STAT]) |-> int_reg[`CBT_INT_MODF] && con_reg[`CBT_CON_STAT] == $past(con_reg[`CBT_CON_REQ]);
  endproperty
  a_mode_flag: assert property (p_mode_flag) else $error("mode change without flag");
  property p_serr_hold;
    int_reg[`CBT_INT_SERR] && con_reg[`CBT_CON_EN] && en_prev_reg |=> int_reg[`CBT_INT_SERR];
  endproperty
  a_serr_hold: assert property (p_serr_hold) else $error("system error flag lost");
  property p_irq;
    ##1 irq_out == |($past(int_reg[31:16]) & $past(int_reg[15:0]));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");
  property p_drain;
    mod_reg != cbt_pkg::MOD_OFF && frame_busy_in |=> ##1 active_out;
  endproperty
  a_drain: assert property (p_drain) else $error("module went idle during a frame");
  property p_wake;
    ##1 wake_rx_out == ($past(cfg_reg[`CBT_CFG_WAKF]) ? $past(wf_reg) : $past(rx_in));
  endproperty
  a_wake: assert property (p_wake) else $error("wake line selection wrong");
  property p_tq;
    run && tick |=> !run || presc_reg == tq_reload;
  endproperty
  a_tq: assert property (p_tq) else $error("quantum reload wrong");
  property p_ph2_end;
    run && tick && !fall && seg_reg == cbt_pkg::SEG_PH2 && qcnt_reg == ph2_len - 4'h1 |=> seg_reg == cbt_pkg::SEG_SYNC;
  endproperty
  a_ph2_end: assert property (p_ph2_end) else $error("phase 2 length wrong");
  property p_prop_end;
    run && tick && !fall && seg_reg == cbt_pkg::SEG_PROP && qcnt_reg == {1'b0, cfg_reg[`CBT_CFG_PROP]}
      |=> seg_reg == cbt_pkg::SEG_PH1;
  endproperty
  a_prop_end: assert property (p_prop_end) else $error("propagation length wrong");
  property p_ph1_end;
    sp && !fall |=> seg_reg == cbt_pkg::SEG_PH2 ##0 sample_strobe_out;
  endproperty
  a_ph1_end: assert property (p_ph1_end) else $error("phase 1 end wrong");
  property p_sample;
    sp |=> sample_out == ($past(cfg_reg[`CBT_CFG_SAM]) ? $past(maj) : $past(rx_in));
  endproperty
  a_sample: assert property (p_sample) else $error("sample value wrong");
  property p_jump;
    ext_reg <= jump;
  endproperty
  a_jump: assert property (p_jump) else $error("resync jump too wide");
  c_sample: cover property (sp && cfg_reg[`CBT_CFG_SAM]);
  c_drain: cover property (mod_reg == cbt_pkg::MOD_DRAIN && frame_busy_in);
  c_irq: cover property (irq_out);
endmodule : cbt_top

/* bench/cbt_bus_node.sv */
// Behavioural CAN bus node that drives the receive line
`timescale 1ns/1ps
module cbt_bus_node (
  // Clock
  input wire logic clk_in,
  // Bus line, recessive high when released
  output logic rx_out
);
  initial rx_out = 1'b1;
  // Holds the line at a level for n clocks, then releases it to recessive
  task automatic drive(input logic lvl, input int n);
    @(posedge clk_in);
    rx_out <= lvl;
    repeat (n) @(posedge clk_in);
    rx_out <= 1'b1;
  endtask : drive
endmodule : cbt_bus_node

/* bench/tb.sv */
// Self-checking testbench for the CAN bit timing and interrupt block
`timescale 1ns/1ps
`include "cbt_consts.svh"
module tb;
  typedef struct {logic [2:0] seg2; logic free; logic triple_sample_select; logic [2:0] seg1; logic [2:0] prop;
    logic [1:0] resync_jump_width; logic [5:0] quantum_prescaler; logic wakf;} cbt_row_t;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] address_in = 4'h0;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic frame_busy_in = 1'b0;
  logic ce_in = 1'b1;
  logic [3:0] byteenable_in = 4'hf;
  logic [7:0] hw_evt_in = 8'h0;
  logic [31:0] readdata_out, rd, c, sticky;
  logic waitrequest_out, irq_out, active_out, wake_rx_out, bit_start_out, sample_strobe_out, sample_out, rx;
  logic [2:0] op_mode_out;
  logic [4:0] data_cmp_count_out;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int n, tq, ph2;
  int fl [8] = '{0, 1, 2, 11, 12, 13, 14, 15};
  cbt_row_t rows [4] = '{'{3'h2, 1'b1, 1'b0, 3'h3, 3'h1, 2'h0, 6'h00, 1'b0},
    '{3'h7, 1'b1, 1'b0, 3'h7, 3'h0, 2'h3, 6'h01, 1'b0},
    '{3'h0, 1'b0, 1'b1, 3'h0, 3'h7, 2'h1, 6'h02, 1'b0},
    '{3'h0, 1'b0, 1'b0, 3'h4, 3'h2, 2'h0, 6'h3f, 1'b1}};
  always #5 clk_in = ~clk_in;
  cbt_bus_node node (.clk_in(clk_in), .rx_out(rx));
  cbt_top #(.WAKE_FILT_CYC(4)) uut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .rx_in(rx), .frame_busy_in(frame_busy_in),
    .hw_evt_in(hw_evt_in), .irq_out(irq_out), .active_out(active_out), .op_mode_out(op_mode_out),
    .data_cmp_count_out(data_cmp_count_out), .wake_rx_out(wake_rx_out), .bit_start_out(bit_start_out),
    .sample_strobe_out(sample_strobe_out), .sample_out(sample_out));
  // ****************************************
  // Harness tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    address_in <= a;
    writedata_in <= d;
    read_in <= !wr;
    write_in <= wr;
    do
    begin
      @(posedge clk_in);
      k++;
    end while (waitrequest_out !== 1'b0);
    rd = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    chk(32'(k), 32'h2, "bus wait states");
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask : rdc
  task automatic set_mode(input logic [2:0] m);
    bus(1'b1, 4'h0, (32'(m) << 24) | 32'h8000);
    n = 0;
    while (op_mode_out !== m && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
    chk(32'(op_mode_out), 32'(m), "mode status");
  endtask : set_mode
  task automatic wait_pulse(input logic strobe);
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while ((strobe ? sample_strobe_out : bit_start_out) !== 1'b1 && n < 5000);
  endtask : wait_pulse
  task automatic glitch(input int len, input logic exp_low, input string msg);
    logic low;
    low = 1'b0;
    fork
      node.drive(1'b0, len);
      repeat (len + 8)
      begin
        @(posedge clk_in);
        if (wake_rx_out === 1'b0)
          low = 1'b1;
      end
    join
    chk({31'h0, low}, {31'h0, exp_low}, msg);
  endtask : glitch
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    chk({29'h0, op_mode_out}, 32'h4, "reset mode");
    chk({27'h0, data_cmp_count_out}, 32'h0, "reset count");
    chk({29'h0, active_out, irq_out, waitrequest_out}, 32'h1, "reset flags");
    rdc(4'h0, `CBT_CON_RST, "reset control");
    rdc(4'h4, 32'h0, "reset timing");
    rdc(4'h8, 32'h0, "reset interrupt");
    rdc(4'hc, 32'h0, "unmapped");
    bus(1'b1, 4'h4, 32'hffff_ffff);
    rdc(4'h4, `CBT_CFG_WMASK, "timing reserved bits");
    bus(1'b1, 4'h4, 32'h0);
    glitch(2, 1'b1, "raw wake line");
    bus(1'b1, 4'h4, 32'h0040_0000);
    glitch(2, 1'b0, "filtered glitch");
    glitch(10, 1'b1, "filtered long low");
    foreach (fl[i])
    begin
      if (i < 2)
      begin
        bus(1'b1, 4'h0, 32'h0400_0000 | (i == 0 ? 32'h1 : 32'h12));
        repeat (2) @(negedge clk_in);
        chk({27'h0, data_cmp_count_out}, i == 0 ? 32'h1 : 32'h12, "compare count");
      end
    end
    foreach (rows[i])
    begin
      set_mode(3'h4);
      c = {9'h0, rows[i].wakf, 3'h0, rows[i].seg2, rows[i].free, rows[i].triple_sample_select, rows[i].seg1, rows[i].prop,
        rows[i].resync_jump_width, rows[i].quantum_prescaler};
      bus(1'b1, 4'h4, c);
      rdc(4'h4, c, "timing accepted");
      bus(1'b1, 4'h8, 32'h0);
      set_mode(3'h0);
      rdc(4'h8, 32'h8, "mode change flag");
      tq = 2 * (int'(rows[i].quantum_prescaler) + 1);
      ph2 = rows[i].free ? int'(rows[i].seg2) + 1 : (rows[i].seg1 > 0 ? int'(rows[i].seg1) + 1 : 2);
      wait_pulse(1'b0);
      wait_pulse(1'b0);
      chk(32'(n), 32'((3 + int'(rows[i].prop) + int'(rows[i].seg1) + ph2) * tq), "bit length");
      wait_pulse(1'b1);
      wait_pulse(1'b0);
      chk(32'(n), 32'((ph2 + 1) * tq), "phase 2 length");
      bus(1'b1, 4'h4, ~c & `CBT_CFG_WMASK);
      rdc(4'h4, c, "timing locked");
    end
    fork
      node.drive(1'b0, 4000);
      begin
        wait_pulse(1'b1);
        wait_pulse(1'b1);
        chk({31'h0, sample_out}, 32'h0, "sampled dominant");
      end
    join
    bus(1'b1, 4'h8, `CBT_INT_ENMASK);
    sticky = 32'h0;
    foreach (fl[i])
    begin
      @(posedge clk_in);
      hw_evt_in <= 8'h1 << i;
      @(posedge clk_in);
      hw_evt_in <= 8'h0;
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h1, "irq raised");
      rdc(4'h8, `CBT_INT_ENMASK | (32'h1 << fl[i]) | sticky, "flag set");
      if (i == 4)
        sticky = 32'h1000;
      bus(1'b1, 4'h8, `CBT_INT_ENMASK);
      rdc(4'h8, `CBT_INT_ENMASK | sticky, "flag cleared");
    end
    bus(1'b1, 4'h8, 32'h0);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0, "irq masked");
    frame_busy_in <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    repeat (20) @(posedge clk_in);
    chk({31'h0, active_out}, 32'h1, "active while busy");
    rdc(4'h0, 32'h800, "active flag held");
    frame_busy_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk({31'h0, active_out}, 32'h0, "inactive after drain");
    rdc(4'h8, 32'h1000, "error flag survives off");
    bus(1'b1, 4'h0, 32'h8000);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd & 32'h1000, 32'h0, "error flag cleared by on");
    @(posedge clk_in);
    ce_in <= 1'b0;
    hw_evt_in <= 8'h01;
    repeat (3) @(posedge clk_in);
    ce_in <= 1'b1;
    hw_evt_in <= 8'h00;
    rdc(4'h8, 32'h0, "event ignored while frozen");
    nrst_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    chk({26'h0, op_mode_out, active_out, irq_out, waitrequest_out}, 32'h21, "mid-run reset");
    rdc(4'h0, `CBT_CON_RST, "control after reset");
    byteenable_in <= 4'h1;
    bus(1'b1, 4'h0, 32'hffff_ff05);
    byteenable_in <= 4'hf;
    rdc(4'h0, `CBT_CON_RST | 32'h5, "byte lane write");
    tally_and_finish();
  end
endmodule : tb
